// >>> rtl/ssi_regs.svh
// Register offsets, field positions and reset values of the safety interlock
`ifndef SSI_REGS_SVH
`define SSI_REGS_SVH

`define SSI_ADDR_W        8
`define SSI_OFF_CTRL      8'h00
`define SSI_OFF_LEVEL     8'h04
`define SSI_OFF_EDGE      8'h08
`define SSI_OFF_SVCDUE    8'h0c
`define SSI_OFF_ZONE_LO   8'h10
`define SSI_OFF_ZONE_HI   8'h14
`define SSI_OFF_POS       8'h18
`define SSI_OFF_STATUS    8'h1c
`define SSI_OFF_IRQ_STAT  8'h20
`define SSI_OFF_IRQ_MASK  8'h24
`define SSI_OFF_EDGE_CLR  8'h28
`define SSI_OFF_FAULT     8'h2c

// Control register fields
`define SSI_CTRL_AUTO     0
`define SSI_CTRL_SERVO    1
`define SSI_CTRL_ERR      2
`define SSI_CTRL_OPESTOP  3
`define SSI_CTRL_TBESTOP  4
`define SSI_CTRL_AXIS     5
`define SSI_CTRL_PWR      6
`define SSI_CTRL_RST      8'h00

// Interrupt status fields
`define SSI_IRQ_ESTOP     0
`define SSI_IRQ_SERVOFF   1
`define SSI_IRQ_FAULT     2
`define SSI_IRQ_EDGE      3
`define SSI_IRQ_W         4

`define SSI_ZONES         8
`define SSI_CHANS         3
`define SSI_EDGE_W        8

`endif

// >>> rtl/ssi_pkg.sv
// Types shared by the safety interlock modules
`default_nettype none
package ssi_pkg;
   typedef struct packed {
      logic [1:0] estop;
      logic [1:0] door;
      logic [1:0] enable;
   } ssi_dual_t;

   typedef struct packed {
      logic robot_err;
      logic estop;
      logic mode;
      logic axis;
   } ssi_contact_t;

   typedef struct packed {
      logic [2:0] pneu;
      logic [2:0] hand;
      logic [2:0] service;
   } ssi_chan_t;

   typedef enum logic [1:0] {
      SSI_DC_OK    = 2'b00,
      SSI_DC_OPEN  = 2'b01,
      SSI_DC_FAULT = 2'b10
   } ssi_dc_state_t;
endpackage : ssi_pkg
`default_nettype wire

// >>> rtl/ssi_dual_chan.sv
// Dual-channel normally-closed input checker with latched mismatch fault
`timescale 1ns/10ps
`default_nettype none
module ssi_dual_chan (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Two contact lines, high means closed
   input  wire logic [1:0] lines,
   // Results
   output logic            open_o,
   output logic            fault_o
);
   import ssi_pkg::*;

   ssi_dc_state_t state_r, state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SSI_DC_OK: begin
            if (lines[0] != lines[1]) state_nxt = SSI_DC_FAULT;
            else if (lines == 2'b00) state_nxt = SSI_DC_OPEN;
         end
         SSI_DC_OPEN: begin
            if (lines[0] != lines[1]) state_nxt = SSI_DC_FAULT;
            else if (lines == 2'b11) state_nxt = SSI_DC_OK;
         end
         SSI_DC_FAULT: begin
            if (lines == 2'b11) state_nxt = SSI_DC_OK;
         end
         default: state_nxt = SSI_DC_FAULT;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) state_r <= SSI_DC_FAULT;
      else state_r <= state_nxt;
   end

   // Fault also counts as open so a half-wired switch always stops
   assign open_o  = (state_r != SSI_DC_OK);
   assign fault_o = (state_r == SSI_DC_FAULT);

   mismatch_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (lines[0] != lines[1]) |=> fault_o)
      else $error("mismatch not latched");
endmodule : ssi_dual_chan
`default_nettype wire

// >>> rtl/ssi_zone_cmp.sv
// Registered range compare for the user-designated area outputs
`timescale 1ns/10ps
`default_nettype none
module ssi_zone_cmp (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Area bounds, enable and current position
   input  wire logic [15:0] lo,
   input  wire logic [15:0] hi,
   input  wire logic        en,
   input  wire logic [15:0] pos,
   // Inside flag
   output logic             inside_o
);
   logic inside_r, inside_nxt;

   always_comb begin
      inside_nxt = en && (pos >= lo) && (pos <= hi);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) inside_r <= 1'b0;
      else inside_r <= inside_nxt;
   end

   assign inside_o = inside_r;
endmodule : ssi_zone_cmp
`default_nettype wire

// >>> rtl/ssi_interlock.sv
// Safety stop and dedicated I/O interlock with Wishbone register access
`timescale 1ns/10ps
`default_nettype none
`include "ssi_regs.svh"
// Functional notes
// - Level inputs keep their function active only while the input is on.
// - Edge inputs activate on off-to-on and stay set after input drops.
// - Three pneumatic fault inputs each drive a matching fault output.
// - Each mechanism's service-due output warns when parts need replacing; no input.
// - Eight user zones, each start/end bound; output high while robot inside.
// - Emergency stop arrives on two lines and stops the robot when asserted.
// - Door and enabling inputs are dual normally-closed; opening forces servo off.
// - Robot error contact stays open while any controller error exists.
// - Emergency output opens on external, panel or pendant emergency stop.
// - Mode contact open in manual, closed in automatic mode.
// - Extra-axis contactor follows robot servo state when an extra axis exists.
// - All special outputs are open while controller power is off.
// - Only one emergency contact connected gives a continuous error.
// - Three hand fault level inputs each drive a matching fault output.
module ssi_interlock (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // Special terminal inputs, high means contact closed
   input  wire ssi_pkg::ssi_dual_t   safety_in,
   // Dedicated level and edge inputs
   input  wire logic [2:0]           pneumatic_fault_in,
   input  wire logic [2:0]           hand_fault_in,
   input  wire logic [7:0]           edge_req_in,
   // Dedicated outputs and contacts, high means closed or on
   output ssi_pkg::ssi_chan_t        chan_out,
   output logic [7:0]                user_zone_indicator,
   output logic [7:0]                edge_state_out,
   output ssi_pkg::ssi_contact_t     contact_out,
   output logic                      servo_enable,
   output logic                      estop_active,
   output logic                      irq
);
   import ssi_pkg::*;

   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  svc_r, svc_nxt;
   logic [7:0]  zen_r, zen_nxt;
   logic [15:0] zlo_r [`SSI_ZONES];
   logic [15:0] zhi_r [`SSI_ZONES];
   logic [15:0] zlo_nxt [`SSI_ZONES];
   logic [15:0] zhi_nxt [`SSI_ZONES];
   logic [15:0] pos_r, pos_nxt;
   logic [2:0]  zsel_r, zsel_nxt;
   logic [7:0]  edge_r, edge_nxt, edge_prev_r;
   logic [`SSI_IRQ_W-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic        ack_r, ack_nxt;
   logic [7:0]  zone_w;
   logic [2:0]  open_w, fault_w;
   logic        any_fault, estop_w, servo_w, err_w, pwr;
   ssi_chan_t    chan_r, chan_nxt;
   ssi_contact_t cont_r, cont_nxt;
   logic        servo_r, estop_r, irq_r;
   logic        wr, rd_req;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction : merge

   // Dual-channel safety inputs: emergency stop, door, enabling device
   ssi_dual_chan u_estop (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .lines   (safety_in.estop),
      .open_o  (open_w[0]),
      .fault_o (fault_w[0])
   );
   ssi_dual_chan u_door (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .lines   (safety_in.door),
      .open_o  (open_w[1]),
      .fault_o (fault_w[1])
   );
   ssi_dual_chan u_enable (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .lines   (safety_in.enable),
      .open_o  (open_w[2]),
      .fault_o (fault_w[2])
   );

   genvar g;
   generate
      for (g = 0; g < `SSI_ZONES; g++) begin : g_zone
         ssi_zone_cmp u_zone (
            .mclk     (mclk),
            .rst_n    (rst_n),
            .lo       (zlo_r[g]),
            .hi       (zhi_r[g]),
            .en       (zen_r[g]),
            .pos      (pos_r),
            .inside_o (zone_w[g])
         );
      end
   endgenerate

   assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
   assign rd_req = wb_cyc_i && wb_stb_i && !ack_r;
   assign pwr    = ctrl_r[`SSI_CTRL_PWR];
   assign any_fault = |fault_w;
   // Estop from external lines, panel or pendant
   assign estop_w = open_w[0] || ctrl_r[`SSI_CTRL_OPESTOP] || ctrl_r[`SSI_CTRL_TBESTOP];
   assign servo_w = ctrl_r[`SSI_CTRL_SERVO] && !estop_w && !open_w[1] && !open_w[2];
   assign err_w   = ctrl_r[`SSI_CTRL_ERR] || any_fault || (|pneumatic_fault_in)
                    || (|hand_fault_in);

   // Register bus
   always_comb begin
      ctrl_nxt = ctrl_r;
      svc_nxt  = svc_r;
      zen_nxt  = zen_r;
      pos_nxt  = pos_r;
      zsel_nxt = zsel_r;
      imsk_nxt = imsk_r;
      zlo_nxt  = zlo_r;
      zhi_nxt  = zhi_r;
      dat_nxt  = 32'h0;
      ack_nxt  = rd_req;
      if (wr) begin
         case (wb_adr_i)
            `SSI_OFF_CTRL:     ctrl_nxt = 8'(merge({24'h0, ctrl_r}, wb_dat_i, wb_sel_i));
            `SSI_OFF_SVCDUE:   svc_nxt  = wb_dat_i[7:0] & 8'h07;
            `SSI_OFF_ZONE_LO: begin
               zsel_nxt = wb_dat_i[18:16];
               zlo_nxt[wb_dat_i[18:16]] = wb_dat_i[15:0];
            end
            `SSI_OFF_ZONE_HI: begin
               zhi_nxt[zsel_r] = wb_dat_i[15:0];
               zen_nxt[zsel_r] = wb_dat_i[31];
            end
            `SSI_OFF_POS:      pos_nxt  = wb_dat_i[15:0];
            `SSI_OFF_IRQ_MASK: imsk_nxt = wb_dat_i[`SSI_IRQ_W-1:0];
            default: ;
         endcase
      end
      if (rd_req && !wb_we_i) begin
         case (wb_adr_i)
            `SSI_OFF_CTRL:     dat_nxt = {24'h0, ctrl_r};
            `SSI_OFF_LEVEL:    dat_nxt = {23'h0, chan_r};
            `SSI_OFF_EDGE:     dat_nxt = {24'h0, edge_r};
            `SSI_OFF_SVCDUE:   dat_nxt = {24'h0, svc_r};
            `SSI_OFF_ZONE_LO:  dat_nxt = {13'h0, zsel_r, zlo_r[zsel_r]};
            `SSI_OFF_ZONE_HI:  dat_nxt = {zen_r[zsel_r], 15'h0, zhi_r[zsel_r]};
            `SSI_OFF_POS:      dat_nxt = {8'h0, zone_w, pos_r};
            `SSI_OFF_STATUS:   dat_nxt = {24'h0, servo_r, estop_r, 2'h0, cont_r};
            `SSI_OFF_IRQ_STAT: dat_nxt = {28'h0, ist_r};
            `SSI_OFF_IRQ_MASK: dat_nxt = {28'h0, imsk_r};
            `SSI_OFF_FAULT:    dat_nxt = {29'h0, fault_w};
            default:           dat_nxt = 32'h0;
         endcase
      end
   end

   // Edge requests, level outputs, contacts and interrupts
   always_comb begin
      edge_nxt = edge_r | (edge_req_in & ~edge_prev_r);
      if (wr && wb_adr_i == `SSI_OFF_EDGE_CLR) begin
         // New rising edge wins over a clear in the same cycle
         edge_nxt = (edge_r & ~wb_dat_i[7:0]) | (edge_req_in & ~edge_prev_r);
      end
      chan_nxt.pneu    = pneumatic_fault_in;
      chan_nxt.hand    = hand_fault_in;
      chan_nxt.service = svc_r[2:0];
      // Contacts open (0) whenever power is off
      cont_nxt.robot_err = pwr && !err_w;
      cont_nxt.estop     = pwr && !estop_w;
      cont_nxt.mode      = pwr && ctrl_r[`SSI_CTRL_AUTO];
      cont_nxt.axis      = pwr && ctrl_r[`SSI_CTRL_AXIS] && servo_w;
      ist_nxt = ist_r;
      if (wr && wb_adr_i == `SSI_OFF_IRQ_STAT) ist_nxt = ist_r & ~wb_dat_i[`SSI_IRQ_W-1:0];
      if (estop_w) ist_nxt[`SSI_IRQ_ESTOP] = 1'b1;
      if (servo_r && !servo_w) ist_nxt[`SSI_IRQ_SERVOFF] = 1'b1;
      if (any_fault) ist_nxt[`SSI_IRQ_FAULT] = 1'b1;
      if (|(edge_req_in & ~edge_prev_r)) ist_nxt[`SSI_IRQ_EDGE] = 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_r      <= `SSI_CTRL_RST;
         svc_r       <= 8'h00;
         zen_r       <= 8'h00;
         pos_r       <= 16'h0000;
         zsel_r      <= 3'h0;
         imsk_r      <= '0;
         ist_r       <= '0;
         dat_r       <= 32'h0;
         ack_r       <= 1'b0;
         edge_r      <= 8'h00;
         edge_prev_r <= 8'h00;
         chan_r      <= '0;
         cont_r      <= '0;
         servo_r     <= 1'b0;
         estop_r     <= 1'b1;
         irq_r       <= 1'b0;
         for (int i = 0; i < `SSI_ZONES; i++) begin
            zlo_r[i] <= 16'h0000;
            zhi_r[i] <= 16'h0000;
         end
      end else begin
         ctrl_r      <= ctrl_nxt;
         svc_r       <= svc_nxt;
         zen_r       <= zen_nxt;
         pos_r       <= pos_nxt;
         zsel_r      <= zsel_nxt;
         imsk_r      <= imsk_nxt;
         ist_r       <= ist_nxt;
         dat_r       <= dat_nxt;
         ack_r       <= ack_nxt;
         edge_r      <= edge_nxt;
         edge_prev_r <= edge_req_in;
         chan_r      <= chan_nxt;
         cont_r      <= cont_nxt;
         servo_r     <= servo_w;
         estop_r     <= estop_w;
         irq_r       <= |(ist_nxt & imsk_r);
         zlo_r       <= zlo_nxt;
         zhi_r       <= zhi_nxt;
      end
   end

   assign wb_dat_o            = dat_r;
   assign wb_ack_o            = ack_r;
   assign chan_out            = chan_r;
   assign user_zone_indicator = zone_w;
   assign edge_state_out      = edge_r;
   assign contact_out         = cont_r;
   assign servo_enable        = servo_r;
   assign estop_active        = estop_r;
   assign irq                 = irq_r;

   level_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 chan_r.pneu == $past(pneumatic_fault_in))
      else $error("pneumatic output lags");
   hand_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      hand_fault_in != 3'h0 |=> chan_out.hand == $past(hand_fault_in))
      else $error("hand fault output missing");
   edge_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (edge_req_in[0] && !edge_prev_r[0]) |=> edge_r[0])
      else $error("edge request lost");
   estop_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
      open_w[0] |=> !contact_out.estop && estop_active)
      else $error("estop contact not open");
   door_servo_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (open_w[1] || open_w[2]) |=> !servo_enable)
      else $error("servo not forced off");
   power_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !pwr |=> contact_out == '0)
      else $error("contact closed without power");
   error_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
      any_fault |=> !contact_out.robot_err)
      else $error("error contact closed on fault");
   mode_auto_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (pwr && !ctrl_r[`SSI_CTRL_AUTO]) |=> !contact_out.mode)
      else $error("mode contact closed in manual");
   axis_sync_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (pwr && ctrl_r[`SSI_CTRL_AXIS]) |=> contact_out.axis == servo_enable)
      else $error("extra axis out of step");
   level_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !pneumatic_fault_in[0] |=> !chan_out.pneu[0])
      else $error("level function not released");
   zone_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !zen_r[0] |=> !user_zone_indicator[0])
      else $error("disabled zone flagged");
   estop_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
      estop_w |=> ist_r[`SSI_IRQ_ESTOP])
      else $error("estop event not recorded");
   // Bus handshake, interrupt bookkeeping and edge clear
   ack_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("bus request not acknowledged");
   ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> irq == |(ist_r & $past(imsk_r)))
      else $error("interrupt line wrong");
   edge_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr && wb_adr_i == `SSI_OFF_EDGE_CLR && wb_dat_i[0] && edge_prev_r[0]) |=> !edge_r[0])
      else $error("edge bit not cleared");
endmodule : ssi_interlock
`default_nettype wire

// >>> dv/ssi_switch_model.sv
// Far-side model: dual-contact safety switches with wiring faults
`timescale 1ns/10ps
`default_nettype none
module ssi_switch_model (
   // Clock
   input  wire logic             mclk,
   // Switch opened by the operator: estop, door, enable
   input  wire logic [2:0]       press,
   // Second contact left unwired
   input  wire logic [2:0]       miss,
   // Contact lines, high means closed
   output var ssi_pkg::ssi_dual_t safety_in
);
   import ssi_pkg::*;
   // Both contacts of a wired switch move together; an unwired one reads open
   always_ff @(posedge mclk) begin
      safety_in.estop  <= {~press[2] & ~miss[2], ~press[2]};
      safety_in.door   <= {~press[1] & ~miss[1], ~press[1]};
      safety_in.enable <= {~press[0] & ~miss[0], ~press[0]};
   end
endmodule : ssi_switch_model
`default_nettype wire

// >>> dv/ssi_interlock_tb.sv
// Self-checking bench of the safety interlock against a behavioural model
`timescale 1ns/10ps
`default_nettype none
`include "ssi_regs.svh"
module ssi_interlock_tb;
   import ssi_pkg::*;
   localparam logic [7:0] TAB [7] = '{8'h63, 8'h62, 8'h43, 8'h23, 8'h6b, 8'h73, 8'h67};
   logic         mclk, rst_n, cyc, stb, we, wb_ack_o, servo_enable, estop_active, irq;
   logic [7:0]   adr, ereq, ctrl, uzi, edge_state_out, emod, ez;
   logic [3:0]   sel;
   logic [31:0]  wdat, rdat, seed, wb_dat_o, rv;
   logic [2:0]   press, miss, flt, pneu, hand;
   logic [15:0]  p;
   logic [15:0]  zlo [8];
   logic [15:0]  zhi [8];
   logic [7:0]   zen;
   ssi_dual_t    safety_in;
   ssi_chan_t    chan_out;
   ssi_contact_t contact_out;
   int           n_mismatch, num_checks, cycles;

   ssi_switch_model i_ssi_switch_model (.mclk(mclk), .press(press), .miss(miss),
      .safety_in(safety_in));
   ssi_interlock i_ssi_interlock (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .safety_in(safety_in), .pneumatic_fault_in(pneu),
      .hand_fault_in(hand), .edge_req_in(ereq), .chan_out(chan_out),
      .user_zone_indicator(uzi), .edge_state_out(edge_state_out), .contact_out(contact_out),
      .servo_enable(servo_enable), .estop_active(estop_active), .irq(irq));

   always #2 mclk = ~mclk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Classic single cycle; ack and read data taken at the same edge
   // Only the run watchdog ends a wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
      do begin
         @(posedge mclk);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      {cyc, stb, we} <= 3'b000;
   endtask : wb

   // Mismatch latches, only both lines closed clears
   task automatic set_sw(input logic [2:0] pr, input logic [2:0] m);
      press <= pr;
      miss <= m;
      for (int i = 0; i < 3; i++) begin
         if (m[i] && !pr[i]) flt[i] = 1'b1;
         else if (!pr[i]) flt[i] = 1'b0;
      end
      repeat (5) @(posedge mclk);
   endtask : set_sw

   task automatic chk_out(input string tn);
      logic est, srv, err;
      logic [3:0] c;
      est = press[2] | flt[2] | ctrl[3] | ctrl[4];
      srv = ctrl[1] & ~est & ~press[1] & ~press[0] & ~|flt;
      err = ctrl[2] | |pneu | |hand | |flt;
      c = ctrl[6] ? {~err, ~est, ctrl[0], srv & ctrl[5]} : 4'h0;
      chk({tn, " contacts"}, 32'(c), 32'(contact_out));
      if (ctrl[6]) begin
         chk({tn, " estop"}, 32'(est), 32'(estop_active));
         chk({tn, " servo"}, 32'(srv), 32'(servo_enable));
      end
      $display("test %s done", tn);
   endtask : chk_out

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("ERROR run length expected below 20000 seen %0d", cycles);
         stop_test();
      end
   end

   initial begin
      {mclk, rst_n, cyc, stb, we, press, miss, pneu, hand, flt} = '0;
      {adr, ereq, ctrl, wdat, sel} = '0;
      seed = 32'h7b2f443e;
      repeat (2) @(posedge mclk);
      chk("reset contacts", 32'h0, 32'(contact_out));
      chk("reset estop", 32'h1, 32'(estop_active));
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      wb(1'b1, 8'h30, 32'hffffffff);
      wb(1'b0, 8'h30, 32'h0);
      chk("unmapped read", 32'h0, rdat);
      foreach (TAB[i]) begin
         ctrl = TAB[i];
         wb(1'b1, `SSI_OFF_CTRL, {24'h0, ctrl});
         repeat (3) @(posedge mclk);
         chk_out("control");
      end
      ctrl = 8'h63;
      wb(1'b1, `SSI_OFF_CTRL, {24'h0, ctrl});
      for (int i = 0; i < 3; i++) begin
         set_sw(3'b001 << i, 3'b000);
         chk_out("switch open");
         set_sw(3'b000, 3'b000);
         chk_out("switch closed");
      end
      set_sw(3'b000, 3'b100);
      repeat (20) @(posedge mclk);
      chk_out("single wire");
      wb(1'b0, `SSI_OFF_FAULT, 32'h0);
      chk("fault single wire", {29'h0, flt[0], flt[1], flt[2]}, rdat);
      set_sw(3'b000, 3'b010);
      set_sw(3'b010, 3'b000);
      chk_out("both open after mismatch");
      wb(1'b0, `SSI_OFF_FAULT, 32'h0);
      chk("fault reg", {29'h0, flt[0], flt[1], flt[2]}, rdat);
      set_sw(3'b000, 3'b000);
      wb(1'b0, `SSI_OFF_FAULT, 32'h0);
      chk("fault cleared", 32'h0, rdat);
      repeat (7) begin
         rv = rnd();
         pneu <= rv[2:0];
         hand <= rv[5:3];
         wb(1'b1, `SSI_OFF_SVCDUE, {29'h0, rv[8:6]});
         repeat (2) @(posedge mclk);
         chk("chan out", {23'h0, rv[2:0], rv[5:3], rv[8:6]}, 32'(chan_out));
         wb(1'b0, `SSI_OFF_LEVEL, 32'h0);
         chk("level reg", {23'h0, rv[2:0], rv[5:3], rv[8:6]}, rdat);
         chk_out("level");
      end
      pneu <= 3'h0;
      hand <= 3'h0;
      wb(1'b1, `SSI_OFF_SVCDUE, 32'h0);
      repeat (2) @(posedge mclk);
      chk("chan off", 32'h0, 32'(chan_out));
      for (int z = 0; z < 8; z++) begin
         rv = rnd();
         zlo[z] = {1'b0, rv[14:0]};
         zhi[z] = zlo[z] + {3'h0, rv[27:15]};
         zen[z] = rv[31] | (z < 3);
         wb(1'b1, `SSI_OFF_ZONE_LO, {13'h0, 3'(z), zlo[z]});
         wb(1'b1, `SSI_OFF_ZONE_HI, {zen[z], 15'h0, zhi[z]});
      end
      for (int k = 0; k < 24; k++) begin
         rv = rnd();
         p = (k % 3 == 0) ? zlo[k / 3] : (k % 3 == 1) ? zhi[k / 3] + 16'h1 : rv[15:0];
         wb(1'b1, `SSI_OFF_POS, {16'h0, p});
         repeat (3) @(posedge mclk);
         for (int z = 0; z < 8; z++) ez[z] = zen[z] & (p >= zlo[z]) & (p <= zhi[z]);
         chk("zone flags", 32'(ez), 32'(uzi));
         wb(1'b0, `SSI_OFF_POS, 32'h0);
         chk("zone read", 32'(ez), 32'(rdat[23:16]));
      end
      $display("test zones done");
      wb(1'b1, `SSI_OFF_EDGE_CLR, 32'hff);
      emod = 8'h00;
      repeat (4) begin
         rv = rnd();
         ereq <= rv[7:0];
         repeat (2) @(posedge mclk);
         ereq <= 8'h00;
         emod |= rv[7:0];
         repeat (3) @(posedge mclk);
         chk("edge state", 32'(emod), 32'(edge_state_out));
      end
      ereq <= 8'h0f;
      repeat (3) @(posedge mclk);
      wb(1'b1, `SSI_OFF_EDGE_CLR, 32'hff);
      repeat (3) @(posedge mclk);
      chk("edge held high", 32'h0, 32'(edge_state_out));
      $display("test edges done");
      ereq <= 8'h00;
      wb(1'b1, `SSI_OFF_IRQ_MASK, 32'h1);
      wb(1'b1, `SSI_OFF_IRQ_STAT, 32'hf);
      repeat (2) @(posedge mclk);
      chk("irq idle", 32'h0, 32'(irq));
      set_sw(3'b100, 3'b000);
      chk("irq raised", 32'h1, 32'(irq));
      set_sw(3'b000, 3'b000);
      wb(1'b1, `SSI_OFF_IRQ_STAT, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq cleared", 32'h0, 32'(irq));
      wb(1'b1, `SSI_OFF_IRQ_MASK, 32'h0);
      set_sw(3'b100, 3'b000);
      wb(1'b0, `SSI_OFF_IRQ_STAT, 32'h0);
      chk("irq status estop", 32'h1, 32'(rdat[`SSI_IRQ_ESTOP]));
      chk("irq masked", 32'h0, 32'(irq));
      set_sw(3'b000, 3'b000);
      $display("test interrupts done");
      stop_test();
   end
endmodule : ssi_interlock_tb
`default_nettype wire
